//--- hw/dmcs_pkg.sv
package dmcs_pkg;
   // ==========================================
   // Register map (debug module interface word addresses)
   localparam logic [6:0] DMCS_ADDR_CONTROL = 7'h10;
   localparam logic [6:0] DMCS_ADDR_STATUS = 7'h11;
   localparam logic [6:0] DMCS_ADDR_HALT_SUMMARY_FIRST = 7'h40;
   localparam int DMCS_ADDR_W = 7;
   localparam int DMCS_DATA_W = 32;
   // ==========================================
   // Control register fields
   localparam int DMCS_CTL_ACTIVE = 0;
   localparam int DMCS_CTL_CORE_RST = 1;
   localparam int DMCS_CTL_ACK_RESET = 28;
   localparam int DMCS_CTL_RESUME_REQ = 30;
   localparam int DMCS_CTL_HALT_REQ = 31;
   // ==========================================
   // Status register fields
   localparam int DMCS_ST_ALL_RESET = 19;
   localparam int DMCS_ST_ANY_RESET = 18;
   localparam int DMCS_ST_ALL_RESACK = 17;
   localparam int DMCS_ST_ANY_RESACK = 16;
   localparam int DMCS_ST_ALL_UNAVAIL = 13;
   localparam int DMCS_ST_ANY_UNAVAIL = 12;
   localparam int DMCS_ST_ALL_RUN = 11;
   localparam int DMCS_ST_ANY_RUN = 10;
   localparam int DMCS_ST_ALL_HALT = 9;
   localparam int DMCS_ST_ANY_HALT = 8;
   localparam int DMCS_ST_AUTHENTICATED = 7;
   localparam int DMCS_ST_VERSION_LSB = 0;
   localparam logic [3:0] DMCS_VERSION = 4'h2;
   // ==========================================
   // Reset values
   localparam logic DMCS_RST_ACTIVE = 1'b0;
   localparam logic DMCS_RST_CORE_RST = 1'b0;
   localparam logic DMCS_RST_HALT_REQ = 1'b0;
   localparam logic DMCS_RST_HAVE_RESET = 1'b1;
   localparam logic DMCS_RST_RESUME_ACK = 1'b0;
   localparam logic [31:0] DMCS_RST_RDATA = 32'h0000_0000;
   // ==========================================
   // Access operations
   typedef enum logic [1:0] {
      DMCS_OP_NOP,
      DMCS_OP_READ,
      DMCS_OP_WRITE,
      DMCS_OP_RSVD
   } dmcs_op_t;
endpackage

//--- hw/dmcs_ctrl_status.sv
`timescale 1ns/1ps
// Functional notes
// - Control hart-select-high and both reset-halt-request bits read zero.
// - Control bit 1 drives core reset; debug module itself stays unaffected.
// - Module-active zero holds all debug state at reset values.
// - While inactive only the module-active bit accepts write data.
// - Status register is read-only; writes have no effect.
// - Status bits 19 and 18 show unacknowledged hart reset.
// - Status bits 17 and 16 show resume acknowledged.
// - Status bits 13 and 12 show hart unavailable.
// - Status bits 11 and 10 show hart running.
// - Status bits 9 and 8 show hart halted.
// - Status bit 7 always one, bit 6 always zero.
// - Status bit 5 reads zero; halt-on-reset uses preset halt request.
// - Bits 22, 15, 14, 4 and reserved status bits read zero.
// - Status version field 3:0 always reads 2.
// - Halt summary bit 0 shows halted; bits 31:1 read zero.
// - Unavailable hart is never reported halted.
// - Hart unavailable while in reset or core reset bit set.
// - Writing one to acknowledge-reset clears the have-reset state.
// - Resume request clears resume-ack; set again when hart resumes.
module dmcs_ctrl_status (
   // Clock and debug reset
   input wire logic clk,
   input wire logic rst_b,
   // Debug module interface access
   input wire logic dmi_req,
   input wire dmcs_pkg::dmcs_op_t dmi_op,
   input wire logic [dmcs_pkg::DMCS_ADDR_W-1:0] dmi_addr,
   input wire logic [dmcs_pkg::DMCS_DATA_W-1:0] dmi_wdata,
   output logic [dmcs_pkg::DMCS_DATA_W-1:0] dmi_rdata,
   output logic dmi_rvalid,
   // Hart state from the core
   input wire logic hart_in_reset,
   input wire logic hart_halted,
   input wire logic hart_running,
   input wire logic hart_resumed,
   // Run control toward the core
   output logic core_rst_req,
   output logic halt_req,
   output logic resume_req,
   output logic dm_active
);
   import dmcs_pkg::*;

   // ==========================================
   // Input synchronisers for core-side levels
   logic [3:0] hs_meta_r;
   logic [3:0] hs_sync_r;
   logic in_rst_s;
   logic halted_s;
   logic running_s;
   logic resumed_s;

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         hs_meta_r <= 4'h0;
         hs_sync_r <= 4'h0;
      end else begin
         hs_meta_r <= {hart_resumed, hart_running, hart_halted, hart_in_reset};
         hs_sync_r <= hs_meta_r;
      end
   end

   assign in_rst_s = hs_sync_r[0];
   assign halted_s = hs_sync_r[1];
   assign running_s = hs_sync_r[2];
   assign resumed_s = hs_sync_r[3];

   // ==========================================
   // Access decode
   logic wr_ctl;
   logic rd_any;
   logic [DMCS_DATA_W-1:0] wd;

   assign wr_ctl = dmi_req && (dmi_op == DMCS_OP_WRITE) && (dmi_addr == DMCS_ADDR_CONTROL);
   assign rd_any = dmi_req && (dmi_op == DMCS_OP_READ);
   assign wd = dmi_wdata;

   // ==========================================
   // Control register
   logic active_r;
   logic core_rst_r;
   logic halt_req_r;
   logic resume_pulse_r;
   logic ack_pulse;
   logic resume_wr;

   // Field writes other than module-active only land while active
   assign ack_pulse = wr_ctl && active_r && wd[DMCS_CTL_ACK_RESET];
   assign resume_wr = wr_ctl && active_r && wd[DMCS_CTL_RESUME_REQ]
                      && !wd[DMCS_CTL_HALT_REQ];

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         active_r <= DMCS_RST_ACTIVE;
      end else if (wr_ctl) begin
         active_r <= wd[DMCS_CTL_ACTIVE];
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         core_rst_r <= DMCS_RST_CORE_RST;
         halt_req_r <= DMCS_RST_HALT_REQ;
      end else if (!active_r) begin
         core_rst_r <= DMCS_RST_CORE_RST;
         halt_req_r <= DMCS_RST_HALT_REQ;
      end else if (wr_ctl) begin
         core_rst_r <= wd[DMCS_CTL_CORE_RST];
         halt_req_r <= wd[DMCS_CTL_HALT_REQ];
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         resume_pulse_r <= 1'b0;
      end else begin
         resume_pulse_r <= resume_wr;
      end
   end

   // ==========================================
   // Hart state tracking
   logic unavail;
   logic have_reset_r;
   logic resume_ack_r;
   logic resume_pend_r;

   assign unavail = in_rst_s || core_rst_r;

   // Set wins over acknowledge in the same cycle
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         have_reset_r <= DMCS_RST_HAVE_RESET;
      end else if (unavail) begin
         have_reset_r <= 1'b1;
      end else if (!active_r) begin
         have_reset_r <= DMCS_RST_HAVE_RESET;
      end else if (ack_pulse) begin
         have_reset_r <= 1'b0;
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         resume_ack_r <= DMCS_RST_RESUME_ACK;
         resume_pend_r <= 1'b0;
      end else if (!active_r) begin
         resume_ack_r <= DMCS_RST_RESUME_ACK;
         resume_pend_r <= 1'b0;
      end else if (resume_wr) begin
         resume_ack_r <= 1'b0;
         resume_pend_r <= 1'b1;
      end else if (resume_pend_r && resumed_s) begin
         resume_ack_r <= 1'b1;
         resume_pend_r <= 1'b0;
      end
   end

   // ==========================================
   // Reported run state
   logic rep_halted;
   logic rep_running;

   assign rep_halted = halted_s && !unavail;
   assign rep_running = running_s && !halted_s && !unavail;

   // ==========================================
   // Read data
   function automatic logic [DMCS_DATA_W-1:0] dmcs_pair(input logic v, input int lsb);
      logic [DMCS_DATA_W-1:0] r;
      r = '0;
      r[lsb] = v;
      r[lsb+1] = v;
      return r;
   endfunction

   logic [DMCS_DATA_W-1:0] ctl_view;
   logic [DMCS_DATA_W-1:0] st_view;
   logic [DMCS_DATA_W-1:0] hs_view;
   logic [DMCS_DATA_W-1:0] rdata_nxt;

   always_comb begin
      ctl_view = '0;
      ctl_view[DMCS_CTL_ACTIVE] = active_r;
      ctl_view[DMCS_CTL_CORE_RST] = core_rst_r;
   end

   always_comb begin
      st_view = '0;
      st_view = st_view | dmcs_pair(have_reset_r, DMCS_ST_ANY_RESET);
      st_view = st_view | dmcs_pair(resume_ack_r, DMCS_ST_ANY_RESACK);
      st_view = st_view | dmcs_pair(unavail, DMCS_ST_ANY_UNAVAIL);
      st_view = st_view | dmcs_pair(rep_running, DMCS_ST_ANY_RUN);
      st_view = st_view | dmcs_pair(rep_halted, DMCS_ST_ANY_HALT);
      st_view[DMCS_ST_AUTHENTICATED] = 1'b1;
      st_view[DMCS_ST_VERSION_LSB +: 4] = DMCS_VERSION;
   end

   always_comb begin
      hs_view = '0;
      hs_view[0] = rep_halted;
   end

   always_comb begin
      case (dmi_addr)
         DMCS_ADDR_CONTROL: rdata_nxt = ctl_view;
         DMCS_ADDR_STATUS: rdata_nxt = st_view;
         DMCS_ADDR_HALT_SUMMARY_FIRST: rdata_nxt = hs_view;
         default: rdata_nxt = '0;
      endcase
   end

   // Status and summary have no write path at all
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         dmi_rdata <= DMCS_RST_RDATA;
         dmi_rvalid <= 1'b0;
      end else begin
         dmi_rvalid <= rd_any;
         if (rd_any) begin
            dmi_rdata <= rdata_nxt;
         end
      end
   end

   // ==========================================
   // Outputs
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         core_rst_req <= DMCS_RST_CORE_RST;
         halt_req <= DMCS_RST_HALT_REQ;
         resume_req <= 1'b0;
         dm_active <= DMCS_RST_ACTIVE;
      end else begin
         core_rst_req <= core_rst_r;
         halt_req <= halt_req_r;
         resume_req <= resume_pulse_r;
         dm_active <= active_r;
      end
   end

   // ==========================================
   // Checks
   sequence s_ack_write;
      ack_pulse && !unavail;
   endsequence

   a_ack_clears_reset: assert property (@(posedge clk) disable iff (!rst_b)
      s_ack_write |=> !have_reset_r)
      else $error("have-reset not cleared by acknowledge");
   a_reset_sets_sticky: assert property (@(posedge clk) disable iff (!rst_b)
      unavail |=> have_reset_r)
      else $error("have-reset not set on hart reset");
   a_core_rst_out: assert property (@(posedge clk) disable iff (!rst_b)
      wr_ctl && active_r |=> ##1 core_rst_req == $past(wd[DMCS_CTL_CORE_RST], 2))
      else $error("core reset output does not follow control bit 1");
   a_inactive_holds: assert property (@(posedge clk) disable iff (!rst_b)
      !active_r |=> !core_rst_r && !resume_ack_r && !halt_req_r)
      else $error("state not held at reset while inactive");
   a_status_read: assert property (@(posedge clk) disable iff (!rst_b)
      rd_any && dmi_addr == DMCS_ADDR_STATUS |=> dmi_rvalid
      && dmi_rdata[3:0] == 4'h2 && dmi_rdata[7:4] == 4'h8
      && dmi_rdata[31:20] == 12'h000 && dmi_rdata[15:14] == 2'b00)
      else $error("status constant fields wrong");
   a_pairs_equal: assert property (@(posedge clk) disable iff (!rst_b)
      rd_any && dmi_addr == DMCS_ADDR_STATUS |=> dmi_rdata[19] == dmi_rdata[18]
      && dmi_rdata[17] == dmi_rdata[16] && dmi_rdata[13] == dmi_rdata[12]
      && dmi_rdata[11] == dmi_rdata[10] && dmi_rdata[9] == dmi_rdata[8])
      else $error("status pair bits differ");
   a_run_halt_excl: assert property (@(posedge clk) disable iff (!rst_b)
      !(rep_running && rep_halted) && !(unavail && (rep_running || rep_halted)))
      else $error("running and halted not exclusive");
   a_summary_read: assert property (@(posedge clk) disable iff (!rst_b)
      rd_any && dmi_addr == DMCS_ADDR_HALT_SUMMARY_FIRST |=>
      dmi_rdata == {31'h0, $past(rep_halted)})
      else $error("halt summary wrong");
   a_resume_ack: assert property (@(posedge clk) disable iff (!rst_b)
      resume_wr |=> !resume_ack_r ##1 (!resumed_s || !active_r || resume_wr)
      or ##1 resume_ack_r)
      else $error("resume acknowledge sequence wrong");
   a_ctl_zero_bits: assert property (@(posedge clk) disable iff (!rst_b)
      rd_any && dmi_addr == DMCS_ADDR_CONTROL |=> dmi_rdata[31:2] == 30'h0)
      else $error("control read-zero bits not zero");
   a_unavail_bits: assert property (@(posedge clk) disable iff (!rst_b)
      rd_any && dmi_addr == DMCS_ADDR_STATUS && core_rst_r |=> dmi_rdata[13]
      && !dmi_rdata[9] && !dmi_rdata[11])
      else $error("unavailable not reported");
   a_resume_out: assert property (@(posedge clk) disable iff (!rst_b)
      resume_wr |=> ##1 resume_req)
      else $error("resume request output missing");
   a_halt_out: assert property (@(posedge clk) disable iff (!rst_b)
      wr_ctl && active_r |=> ##1 halt_req == $past(wd[DMCS_CTL_HALT_REQ], 2))
      else $error("halt request output does not follow control bit 31");
   a_status_excl: assert property (@(posedge clk) disable iff (!rst_b)
      rd_any && dmi_addr == DMCS_ADDR_STATUS |=> !(dmi_rdata[11] && dmi_rdata[9])
      && !(dmi_rdata[13] && (dmi_rdata[11] || dmi_rdata[9])))
      else $error("status run state not exclusive");
   a_inactive_sticky: assert property (@(posedge clk) disable iff (!rst_b)
      !active_r && !unavail |=> have_reset_r)
      else $error("have-reset not at reset value while inactive");
endmodule

//--- dv/dmcs_hart_model.sv
`timescale 1ns/1ps
// ==========================================
// Behavioural hart behind the run-control lines
module dmcs_hart_model (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // Run control from the debug module
   input wire logic core_rst_req,
   input wire logic halt_req,
   input wire logic resume_req,
   // Fault commanded by the bench: halted shown while in reset
   input wire logic stuck_halt,
   // Hart state
   output logic hart_in_reset,
   output logic hart_halted,
   output logic hart_running,
   output logic hart_resumed
);
   logic halted_r;
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) hart_in_reset <= 1'b0;
      else hart_in_reset <= core_rst_req;
   end
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) halted_r <= 1'b0;
      else if (core_rst_req || hart_in_reset || resume_req) halted_r <= 1'b0;
      else if (halt_req) halted_r <= 1'b1;
   end
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) hart_resumed <= 1'b0;
      else if (hart_in_reset) hart_resumed <= 1'b0;
      else if (resume_req) hart_resumed <= 1'b1;
      else if (halted_r) hart_resumed <= 1'b0;
   end
   assign hart_halted = halted_r | stuck_halt;
   assign hart_running = !hart_in_reset && !halted_r;
endmodule

//--- dv/testbench.sv
`timescale 1ns/1ps
module testbench;
   import dmcs_pkg::*;
   localparam logic [31:0] B = 32'h0000_0082;
   localparam logic [31:0] HR = 32'h000C_0000;
   localparam logic [31:0] RA = 32'h0003_0000;
   localparam logic [31:0] UN = 32'h0000_3000;
   localparam logic [31:0] RUN = 32'h0000_0C00;
   localparam logic [31:0] HLT = 32'h0000_0300;
   logic clk, rst_b, dmi_req, dmi_rvalid, stuck_halt;
   dmcs_op_t dmi_op;
   logic [6:0] dmi_addr;
   logic [31:0] dmi_wdata, dmi_rdata;
   logic h_rst, h_halt, h_run, h_res, core_rst_req, halt_req, resume_req, dm_active;
   int err_count = 0;
   int samples_checked = 0;
   int cycles = 0;
   int resume_cnt = 0;
   dmcs_ctrl_status u_dmcs_ctrl_status (.clk(clk), .rst_b(rst_b), .dmi_req(dmi_req),
      .dmi_op(dmi_op), .dmi_addr(dmi_addr), .dmi_wdata(dmi_wdata), .dmi_rdata(dmi_rdata),
      .dmi_rvalid(dmi_rvalid), .hart_in_reset(h_rst), .hart_halted(h_halt),
      .hart_running(h_run), .hart_resumed(h_res), .core_rst_req(core_rst_req),
      .halt_req(halt_req), .resume_req(resume_req), .dm_active(dm_active));
   dmcs_hart_model u_dmcs_hart_model (.clk(clk), .rst_b(rst_b), .core_rst_req(core_rst_req),
      .halt_req(halt_req), .resume_req(resume_req), .stuck_halt(stuck_halt),
      .hart_in_reset(h_rst), .hart_halted(h_halt), .hart_running(h_run),
      .hart_resumed(h_res));
   // ==========================================
   // Clock, resume pulse count, hang guard
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   always @(posedge clk) begin
      cycles++;
      if (resume_req === 1'b1) resume_cnt++;
      if (cycles == 3000) begin
         err_count++;
         report_and_stop();
      end
   end
   // ==========================================
   // Access and check tasks
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         err_count++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic acc(input dmcs_op_t op, input logic [6:0] a, input logic [31:0] d);
      @(negedge clk);
      dmi_req = 1'b1;
      dmi_op = op;
      dmi_addr = a;
      dmi_wdata = d;
      @(negedge clk);
      dmi_req = 1'b0;
      dmi_op = DMCS_OP_NOP;
   endtask
   // Writes wait out the hart-state synchroniser and the model
   task automatic wr(input logic [6:0] a, input logic [31:0] d);
      acc(DMCS_OP_WRITE, a, d);
      repeat (6) @(negedge clk);
   endtask
   task automatic rd(input logic [6:0] a, input logic [31:0] exp);
      int n;
      n = 0;
      acc(DMCS_OP_READ, a, 32'h0);
      while (dmi_rvalid !== 1'b1 && n < 3) begin
         @(negedge clk);
         n++;
      end
      chk({31'h0, dmi_rvalid}, 32'h1);
      chk(dmi_rdata, exp);
   endtask
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   // ==========================================
   // Test sequence
   initial begin
      rst_b = 1'b0;
      dmi_req = 1'b0;
      dmi_op = DMCS_OP_NOP;
      dmi_addr = 7'h00;
      dmi_wdata = 32'h0;
      stuck_halt = 1'b0;
      repeat (10) @(negedge clk);
      rst_b = 1'b1;
      // Let the hart-state synchroniser fill before the first status read
      repeat (3) @(negedge clk);
      rd(DMCS_ADDR_STATUS, B | HR | RUN);
      rd(DMCS_ADDR_HALT_SUMMARY_FIRST, 32'h0);
      rd(7'h12, 32'h0);
      $display("test reset_state done");
      wr(DMCS_ADDR_CONTROL, 32'h9000_000F);
      rd(DMCS_ADDR_CONTROL, 32'h1);
      chk({29'h0, dm_active, core_rst_req, halt_req}, 32'h4);
      rd(DMCS_ADDR_STATUS, B | HR | RUN);
      wr(DMCS_ADDR_CONTROL, 32'h1000_0001);
      rd(DMCS_ADDR_STATUS, B | RUN);
      wr(DMCS_ADDR_CONTROL, 32'h0000_FFFD);
      rd(DMCS_ADDR_CONTROL, 32'h1);
      $display("test activate done");
      wr(DMCS_ADDR_CONTROL, 32'h3);
      stuck_halt = 1'b1;
      repeat (6) @(negedge clk);
      chk({30'h0, dm_active, core_rst_req}, 32'h3);
      rd(DMCS_ADDR_STATUS, B | HR | UN);
      rd(DMCS_ADDR_HALT_SUMMARY_FIRST, 32'h0);
      stuck_halt = 1'b0;
      wr(DMCS_ADDR_CONTROL, 32'h1);
      rd(DMCS_ADDR_STATUS, B | HR | RUN);
      wr(DMCS_ADDR_CONTROL, 32'h1000_0001);
      $display("test core_reset done");
      wr(DMCS_ADDR_CONTROL, 32'h8000_0001);
      chk({31'h0, halt_req}, 32'h1);
      rd(DMCS_ADDR_STATUS, B | HLT);
      rd(DMCS_ADDR_HALT_SUMMARY_FIRST, 32'h1);
      wr(DMCS_ADDR_STATUS, 32'hFFFF_FFFF);
      rd(DMCS_ADDR_STATUS, B | HLT);
      wr(DMCS_ADDR_CONTROL, 32'hC000_0001);
      chk(resume_cnt, 32'h0);
      wr(DMCS_ADDR_CONTROL, 32'h4000_0001);
      chk(resume_cnt, 32'h1);
      rd(DMCS_ADDR_STATUS, B | RA | RUN);
      $display("test halt_resume done");
      wr(DMCS_ADDR_CONTROL, 32'h0);
      chk({31'h0, dm_active}, 32'h0);
      rd(DMCS_ADDR_STATUS, B | HR | RUN);
      wr(DMCS_ADDR_CONTROL, 32'h1);
      chk({31'h0, dm_active}, 32'h1);
      $display("test deactivate done");
      report_and_stop();
   end
endmodule
